// ---- rrs_pkg.sv ----
// Package of constants and types for the rotate-right and subtract-with-borrow ALU slice.
package rrs_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] ADDR_CMD     = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_ACCUM   = 8'h08;
   localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
   localparam logic [7:0] ADDR_IMMED   = 8'h10;

   // ==========================================================================
   // Command codes written to the command register
   localparam logic [2:0] OP_NONE                        = 3'h0;
   localparam logic [2:0] OP_ROTATE_RIGHT_MEM            = 3'h1;
   localparam logic [2:0] OP_ROTATE_RIGHT_TO_ACCUM       = 3'h2;
   localparam logic [2:0] OP_ROTATE_RIGHT_CARRY_MEM      = 3'h3;
   localparam logic [2:0] OP_ROTATE_RIGHT_CARRY_TO_ACCUM = 3'h4;
   localparam logic [2:0] OP_SUBTRACT_WITH_BORROW_MEM    = 3'h5;
   localparam logic [2:0] OP_SUBTRACT_WITH_BORROW_IMM    = 3'h6;

   // ==========================================================================
   // Flag register field positions
   localparam int FLAG_C_POS  = 0;
   localparam int FLAG_AC_POS = 1;
   localparam int FLAG_Z_POS  = 2;
   localparam int FLAG_OV_POS = 3;
   localparam int FLAG_SC_POS = 4;
   localparam int FLAG_CZ_POS = 5;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] ACCUM_RST   = 8'h00;
   localparam logic [7:0] OPERAND_RST = 8'h00;
   localparam logic [7:0] IMMED_RST   = 8'h00;

   typedef struct packed {
      logic cz;
      logic sc;
      logic ov;
      logic z;
      logic ac;
      logic c;
   } rrs_flags_type;

   localparam rrs_flags_type FLAGS_RST = '{default: 1'b0};

   typedef struct packed {
      logic [7:0]    accum;
      logic [7:0]    operand;
      rrs_flags_type flags;
   } rrs_result_type;

endpackage

// ---- rrs_alu.sv ----
// APB-reached rotate-right and subtract-with-borrow datapath slice.
`timescale 1ns/10ps
// Function
// RULE1: Rotate right of the memory operand wraps bit 0 into bit 7, writes memory back, flags untouched.
// RULE2: Rotate right to accumulator does the same rotation into the accumulator, memory and flags untouched.
// RULE3: Rotate right through carry shifts a 9-bit ring, carry into bit 7, bit 0 into carry, memory written.
// RULE4: Rotate right through carry to accumulator does the same ring rotation into the accumulator.
// RULE5: Subtract with borrow from memory takes the operand and the inverted carry from the accumulator.
// RULE6: After a subtract with borrow carry is 0 on a borrow and 1 when the result is zero or positive.
// RULE7: A subtract with borrow updates overflow, zero, aux carry, carry, signed carry and chained zero.
// RULE8: Subtract with borrow of an immediate uses the immediate byte with the same result and flag rules.
module rrs_alu (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr
);
   import rrs_pkg::*;

   // ==========================================================================
   // State
   logic [7:0]     accum_ff;
   logic [7:0]     operand_ff;
   logic [7:0]     immed_ff;
   logic [2:0]     last_op_ff;
   rrs_flags_type  flags_ff;
   logic           pready_ff;
   logic [31:0]    prdata_ff;
   logic           pslverr_ff;

   // ==========================================================================
   // Bus decode nets
   logic           setup;
   logic           access_wr;
   logic           addr_ok;
   logic           cmd_ok;
   logic           sel_cmd;
   logic           sel_operand;
   logic           sel_accum;
   logic           sel_flags;
   logic           sel_immed;
   logic           wr_cmd;
   logic           wr_operand;
   logic           wr_accum;
   logic           wr_flags;
   logic           wr_immed;
   logic [31:0]    rd_word;

   // ==========================================================================
   // Command decode nets
   logic           is_rot_mem;
   logic           is_rot_accum;
   logic           is_rotc_mem;
   logic           is_rotc_accum;
   logic           is_sub;

   // ==========================================================================
   // Datapath nets
   logic [7:0]     rot_plain;
   logic [7:0]     rot_carry;
   logic [7:0]     sub_src;
   logic [8:0]     borrow;
   logic [8:0]     diff9;
   logic [4:0]     diff_low;
   logic [7:0]     diff;
   logic           sub_ov;
   logic           sub_c;
   logic           sub_ac;
   logic           sub_z;
   logic           sub_sc;
   logic           sub_cz;
   rrs_result_type nxt_result;

   // ==========================================================================
   // Bus phases
   // A write lands only in an error-free access, so a refused transfer changes nothing.
   assign setup     = psel & ~penable;
   assign access_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   always_comb begin
      sel_cmd     = (paddr[31:8] == 24'h000000) && (paddr[7:0] == ADDR_CMD);
      sel_operand = (paddr[31:8] == 24'h000000) && (paddr[7:0] == ADDR_OPERAND);
      sel_accum   = (paddr[31:8] == 24'h000000) && (paddr[7:0] == ADDR_ACCUM);
      sel_flags   = (paddr[31:8] == 24'h000000) && (paddr[7:0] == ADDR_FLAGS);
      sel_immed   = (paddr[31:8] == 24'h000000) && (paddr[7:0] == ADDR_IMMED);
      addr_ok     = sel_cmd | sel_operand | sel_accum | sel_flags | sel_immed;
      cmd_ok      = (pwdata[2:0] <= OP_SUBTRACT_WITH_BORROW_IMM) && (pwdata[31:3] == 29'h0);
   end

   assign wr_cmd     = access_wr & sel_cmd;
   assign wr_operand = access_wr & sel_operand;
   assign wr_accum   = access_wr & sel_accum;
   assign wr_flags   = access_wr & sel_flags;
   assign wr_immed   = access_wr & sel_immed;

   // ==========================================================================
   // Command code decode
   always_comb begin
      is_rot_mem    = (pwdata[2:0] == OP_ROTATE_RIGHT_MEM);
      is_rot_accum  = (pwdata[2:0] == OP_ROTATE_RIGHT_TO_ACCUM);
      is_rotc_mem   = (pwdata[2:0] == OP_ROTATE_RIGHT_CARRY_MEM);
      is_rotc_accum = (pwdata[2:0] == OP_ROTATE_RIGHT_CARRY_TO_ACCUM);
      is_sub        = (pwdata[2:0] == OP_SUBTRACT_WITH_BORROW_MEM) ||
                      (pwdata[2:0] == OP_SUBTRACT_WITH_BORROW_IMM);
   end

   // ==========================================================================
   // Rotator
   // Both rotations share the shift; only the bit that wraps into the top differs.
   for (genvar gi = 0; gi < 8; gi++) begin : g_rot_bit
      if (gi < 7) begin : g_shift
         assign rot_plain[gi] = operand_ff[gi + 1];                     // see RULE1
         assign rot_carry[gi] = operand_ff[gi + 1];                     // see RULE3
      end else begin : g_wrap
         assign rot_plain[gi] = operand_ff[0];                          // see RULE2
         assign rot_carry[gi] = flags_ff.c;                             // see RULE4
      end
   end

   // ==========================================================================
   // Subtractor shared by both subtract commands
   // A ripple borrow chain gives the nibble borrow for aux carry without a second adder.
   always_comb begin
      sub_src = (pwdata[2:0] == OP_SUBTRACT_WITH_BORROW_IMM) ? immed_ff : operand_ff;   // see RULE8
   end

   assign borrow[0] = ~flags_ff.c;                                      // see RULE5

   for (genvar gj = 0; gj < 8; gj++) begin : g_sub_bit
      logic bit_ne;
      assign bit_ne         = accum_ff[gj] ^ sub_src[gj];
      assign diff[gj]       = bit_ne ^ borrow[gj];
      assign borrow[gj + 1] = (~accum_ff[gj] & sub_src[gj]) | (~bit_ne & borrow[gj]);
   end

   assign diff9    = {borrow[8], diff};
   assign diff_low = {borrow[4], diff[3:0]};
   assign sub_ov   = (accum_ff[7] ^ sub_src[7]) & (accum_ff[7] ^ diff[7]);

   // ==========================================================================
   // Subtract flags
   // Chained zero only stays set while every result of a multi-byte chain is zero.
   assign sub_c  = ~diff9[8];                                           // see RULE6
   assign sub_ac = ~diff_low[4];                                        // see RULE7
   assign sub_z  = (diff == 8'h00);                                     // see RULE7
   assign sub_sc = sub_ov ^ diff[7];                                    // see RULE7
   assign sub_cz = sub_z & flags_ff.cz;                                 // see RULE7

   // ==========================================================================
   // Next accumulator
   always_comb begin
      nxt_result.accum = accum_ff;
      if (is_rot_accum) begin
         nxt_result.accum = rot_plain;                                  // see RULE2
      end else if (is_rotc_accum) begin
         nxt_result.accum = rot_carry;                                  // see RULE4
      end else if (is_sub) begin
         nxt_result.accum = diff;                                       // see RULE5
      end
   end

   // Next memory operand; the to-accumulator forms leave it as it is.
   always_comb begin
      nxt_result.operand = operand_ff;
      if (is_rot_mem) begin
         nxt_result.operand = rot_plain;                                // see RULE1
      end else if (is_rotc_mem) begin
         nxt_result.operand = rot_carry;                                // see RULE3
      end
   end

   // Next flags; the plain rotations keep every flag.
   always_comb begin
      nxt_result.flags = flags_ff;
      if (is_rotc_mem | is_rotc_accum) begin
         nxt_result.flags.c = operand_ff[0];                            // see RULE3
      end else if (is_sub) begin
         nxt_result.flags.c  = sub_c;                                   // see RULE6
         nxt_result.flags.ac = sub_ac;                                  // see RULE7
         nxt_result.flags.z  = sub_z;                                   // see RULE7
         nxt_result.flags.ov = sub_ov;                                  // see RULE7
         nxt_result.flags.sc = sub_sc;                                  // see RULE7
         nxt_result.flags.cz = sub_cz;                                  // see RULE7
      end
   end

   // ==========================================================================
   // APB handshake
   // Ready registered from the setup cycle adds no wait state and still lets read data come from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // An illegal command is refused in its own access, so it never reaches the datapath.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup & (~addr_ok | (pwrite & sel_cmd & ~cmd_ok));
      end
   end

   // ==========================================================================
   // Read path
   // The word is captured in the setup cycle; a write in the same access cannot race it.
   always_comb begin
      rd_word = 32'h00000000;
      unique case (paddr[7:0])
         ADDR_CMD:     rd_word = {29'h0, last_op_ff};
         ADDR_OPERAND: rd_word = {24'h0, operand_ff};
         ADDR_ACCUM:   rd_word = {24'h0, accum_ff};
         ADDR_FLAGS:   rd_word = {26'h0, flags_ff};
         ADDR_IMMED:   rd_word = {24'h0, immed_ff};
         default:      rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else if (setup & ~pwrite) begin
         prdata_ff <= rd_word;
      end
   end

   // ==========================================================================
   // Datapath registers
   // A command runs at the edge that completes its write, from the values before it.
   // One address per transfer, so a software load and a command never collide.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum_ff <= ACCUM_RST;
      end else if (wr_accum) begin
         accum_ff <= pwdata[7:0];
      end else if (wr_cmd) begin
         accum_ff <= nxt_result.accum;                                  // see RULE5
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operand_ff <= OPERAND_RST;
      end else if (wr_operand) begin
         operand_ff <= pwdata[7:0];
      end else if (wr_cmd) begin
         operand_ff <= nxt_result.operand;                              // see RULE1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= FLAGS_RST;
      end else if (wr_flags) begin
         flags_ff <= pwdata[5:0];
      end else if (wr_cmd) begin
         flags_ff <= nxt_result.flags;                                  // see RULE7
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         immed_ff <= IMMED_RST;
      end else if (wr_immed) begin
         immed_ff <= pwdata[7:0];                                       // see RULE8
      end
   end

   // The last command code is kept so software can read back what ran.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_op_ff <= OP_NONE;
      end else if (wr_cmd) begin
         last_op_ff <= pwdata[2:0];
      end
   end

   // ==========================================================================
   // Outputs
   // Every output comes straight from its flip-flop.
   assign pready  = pready_ff;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

endmodule

// ---- rrs_mem_model.sv ----
// Reference model of the decoder and data memory side of the ALU slice.
`timescale 1ns/10ps
module rrs_mem_model (
   input  wire logic [2:0]              op,
   input  wire rrs_pkg::rrs_result_type cur,
   input  wire logic [7:0]              imm,
   output rrs_pkg::rrs_result_type      exp_res
);
   import rrs_pkg::*;
   // ==========================================
   // Expected state after one command
   always_comb begin
      logic [7:0] s;
      logic [8:0] d;
      logic [4:0] n;
      exp_res = cur;
      s = (op == OP_SUBTRACT_WITH_BORROW_IMM) ? imm : cur.operand;
      d = {1'b0, cur.accum} - {1'b0, s} - {8'h00, ~cur.flags.c};
      n = {1'b0, cur.accum[3:0]} - {1'b0, s[3:0]} - {4'h0, ~cur.flags.c};
      case (op)
         OP_ROTATE_RIGHT_MEM: exp_res.operand = {cur.operand[0], cur.operand[7:1]};
         OP_ROTATE_RIGHT_TO_ACCUM: exp_res.accum = {cur.operand[0], cur.operand[7:1]};
         OP_ROTATE_RIGHT_CARRY_MEM: begin
            exp_res.operand = {cur.flags.c, cur.operand[7:1]};
            exp_res.flags.c = cur.operand[0];
         end
         OP_ROTATE_RIGHT_CARRY_TO_ACCUM: begin
            exp_res.accum = {cur.flags.c, cur.operand[7:1]};
            exp_res.flags.c = cur.operand[0];
         end
         OP_SUBTRACT_WITH_BORROW_MEM, OP_SUBTRACT_WITH_BORROW_IMM: begin
            exp_res.accum = d[7:0];
            exp_res.flags.c = ~d[8];
            exp_res.flags.ac = ~n[4];
            exp_res.flags.z = (d[7:0] == 8'h00);
            exp_res.flags.ov = (cur.accum[7] ^ s[7]) & (cur.accum[7] ^ d[7]);
            exp_res.flags.sc = exp_res.flags.ov ^ d[7];
            exp_res.flags.cz = exp_res.flags.z & cur.flags.cz;
         end
         default: ;
      endcase
   end
endmodule

// ---- rrs_alu_chk.sv ----
// Checker of the register bus behaviour of the ALU slice.
`timescale 1ns/10ps
module rrs_alu_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr
);
   import rrs_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bad_cmd;
      psel && !penable && pwrite && paddr == 32'(ADDR_CMD) && pwdata > 32'h6;
   endsequence
   property p_ready_next; s_setup |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
   property p_ready_once; pready |=> !pready; endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held too long");
   property p_ready_access; pready |-> psel && penable; endproperty
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_bad_cmd; s_bad_cmd |=> pslverr; endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("bad command accepted");
   property p_unmapped; s_setup && paddr > 32'h10 |=> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
   property p_rdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
endmodule
bind rrs_alu rrs_alu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr));

// ---- rotate_right_subtract_carry_alu_tb.sv ----
// Self-checking testbench of the ALU slice.
`timescale 1ns/10ps
module rotate_right_subtract_carry_alu_tb;
   import rrs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd, r, seed = 32'd61043;
   logic [2:0] op;
   logic [7:0] imm;
   rrs_result_type cur, exp_res, got;
   int miscompares = 0, checked = 0;
   rrs_alu u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));
   rrs_mem_model u_model (.op(op), .cur(cur), .imm(imm), .exp_res(exp_res));
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // ==========================================
   // One bus transfer, then an idle edge before the next
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); end while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task stop_test();
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #500000;
      miscompares++;
      stop_test();
   end
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; op = 0; imm = 0;
      cur = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      apb(0, 32'(ADDR_FLAGS), 0); chk(rd, 0);
      for (int i = 0; i < 140; i++) begin
         r = rnd(); cur = rrs_result_type'(r[21:0]); r = rnd(); imm = r[7:0];
         if (i % 3 == 0) cur.operand = cur.accum; // Equal operands reach the zero result when carry is set.
         if (i % 5 == 0) imm = cur.accum;
         op = 3'(i % 7);
         apb(1, 32'(ADDR_ACCUM), {24'h0, cur.accum});
         apb(1, 32'(ADDR_OPERAND), {24'h0, cur.operand});
         apb(1, 32'(ADDR_FLAGS), {26'h0, cur.flags});
         apb(1, 32'(ADDR_IMMED), {24'h0, imm});
         apb(1, 32'(ADDR_CMD), {29'h0, op}); chk({31'h0, err}, 0);
         apb(0, 32'(ADDR_CMD), 0); chk(rd, {29'h0, op});
         apb(0, 32'(ADDR_ACCUM), 0); got.accum = rd[7:0];
         apb(0, 32'(ADDR_OPERAND), 0); got.operand = rd[7:0];
         apb(0, 32'(ADDR_FLAGS), 0); got.flags = rd[5:0];
         chk({10'h0, got}, {10'h0, exp_res});
      end
      apb(1, 32'(ADDR_CMD), 32'h7); chk({31'h0, err}, 1);
      apb(0, 32'h14, 0); chk({31'h0, err}, 1);
      apb(0, 32'(ADDR_ACCUM), 0); chk(rd, {24'h0, exp_res.accum});
      stop_test();
   end
endmodule
